/* File: verilog/rmsc_ctrl.sv */
/*
 operating-mode state machine and sideband control of a four-lane re-driver.
 assumes all inputs synchronous to CORE_CLK_I; aux command decode, activity
 monitor and configuration checks are done outside and arrive as levels/pulses.
*/
// Overview of operation
// - enable and chip reset high: leave shutdown
// - standby to active on sink presence high
// - active to deep power-down on aux entry, port sinks only
// - deep power-down exit on aux or adapter
// - long presence low falls back to standby
// - enable or chip reset low: shutdown now
// - inactive video stream squelches to output disable
// - active video again returns to active
// - invalid config forces output disable until fixed
// - chip reset low: defaults, lanes off
// - lanes stay off until config programmed
// - presence output shows detected sink
// - adapter detect selects port or tmds mode
// - short presence pulses pass through, stay active
// - tmds: no training, default swing until written
// - tmds enables all four lanes
// - override ignores detect inputs, drives programmed values
// - presence low: all sideband paths off
// - default sideband routing per sink type
// - forbidden 101h/103h value disables outputs
// - enable low keeps config; only reset clears
`timescale 1ns/1ps
`include "rmsc_params.svh"
module rmsc_ctrl #(
   parameter int UNPLUG_CYCLES = `RMSC_UNPLUG_US * `RMSC_CLK_MHZ,
   parameter int IRQ_MAX_CYCLES = `RMSC_IRQ_MAX_US * `RMSC_CLK_MHZ
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic ENABLE_I,
   input wire logic CHIP_RESET_LOW_I,
   input wire logic SINK_PRESENCE_IN_I,
   input wire logic CABLE_ADAPTER_DETECT_IN_I,
   input wire logic DEEP_POWER_DOWN_ENTRY_I,
   input wire logic DEEP_POWER_DOWN_EXIT_I,
   input wire logic STREAM_ACTIVE_I,
   input wire logic CONFIG_INVALID_I,
   input wire logic CONFIG_WRITE_I,
   input wire logic TRAINING_DONE_I,
   input wire logic [`RMSC_LANES-1:0] TRAINED_LANES_I,
   input wire logic ALT_SIDEBAND_I,
   input wire logic ALT_JOIN_I,
   input wire rmsc_pkg::rmsc_override_t OVERRIDE_I,
   input wire logic SWING_WRITE_I,
   input wire logic [1:0] SWING_I,
   input wire logic [1:0] EMPHASIS_I,
   output rmsc_pkg::rmsc_mode_t MODE_O,
   output logic PRESENCE_TO_SOURCE_O,
   output logic CABLE_ADAPTER_TO_SOURCE_O,
   output rmsc_pkg::rmsc_sideband_t SIDEBAND_O,
   output logic [`RMSC_LANES-1:0] LANE_EN_O,
   output logic TRAINING_EN_O,
   output logic CONFIG_CLEAR_O,
   output logic [1:0] SWING_O,
   output logic [1:0] EMPHASIS_O
);
   import rmsc_pkg::*;

   // counter width follows the timeout, so the full-length default fits at any clock rate
   localparam int CNT_W = $clog2(UNPLUG_CYCLES + 1);

   // an unplug wait no longer than an interrupt pulse would drop the sink on every request
   if (UNPLUG_CYCLES <= IRQ_MAX_CYCLES || IRQ_MAX_CYCLES < 1) begin : bad_timeout
      $error("unplug timeout must exceed the interrupt pulse");
   end

   rmsc_mode_t mode; // current mode
   rmsc_mode_t next_mode; // mode after this edge
   logic [CNT_W-1:0] low_count; // cycles presence has stayed low
   logic unplugged; // presence low for at least the timeout
   logic programmed; // config set since chip reset released
   logic run; // enable and chip reset both high
   logic presence; // effective presence after override
   logic adapter; // effective adapter detect after override
   logic [CNT_W-1:0] timeout; // timeout count at counter width

   assign run = ENABLE_I && CHIP_RESET_LOW_I;
   // test override replaces the detect inputs
   assign presence = OVERRIDE_I.force_detect ? OVERRIDE_I.presence_value : SINK_PRESENCE_IN_I;
   assign adapter = OVERRIDE_I.force_detect ? OVERRIDE_I.adapter_value : CABLE_ADAPTER_DETECT_IN_I;
   // timeout cut to the counter width, which was sized to hold it
   assign timeout = CNT_W'(UNPLUG_CYCLES);
   // an interrupt pulse is far shorter than this, so it never reads as an unplug
   assign unplugged = low_count >= timeout;

   // low-time counter; saturates so a long unplug never wraps to look short
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         low_count <= '0;
      end else if (presence) begin
         // any high sample restarts the count
         low_count <= '0;
      end else if (!unplugged) begin
         low_count <= low_count + CNT_W'(1);
      end
   end

   // mode transitions; shutdown and config error take priority over all else
   always_comb begin
      next_mode = mode;
      unique case (mode)
         RMSC_SHUT: begin
            if (run) next_mode = RMSC_STBY;
         end
         RMSC_STBY: begin
            if (presence) next_mode = RMSC_ACT;
         end
         RMSC_ACT: begin
            if (unplugged) next_mode = RMSC_STBY;
            else if (DEEP_POWER_DOWN_ENTRY_I && !adapter) next_mode = RMSC_D3;
            else if (!STREAM_ACTIVE_I) next_mode = RMSC_ODIS;
         end
         RMSC_D3: begin
            if (unplugged) next_mode = RMSC_STBY;
            else if (DEEP_POWER_DOWN_EXIT_I || adapter) next_mode = RMSC_ACT;
         end
         RMSC_ODIS: begin
            // leave only once config is valid; then pick the mode that applies
            if (!CONFIG_INVALID_I) begin
               if (unplugged) next_mode = RMSC_STBY;
               else if (presence && STREAM_ACTIVE_I) next_mode = RMSC_ACT;
            end
         end
         default: next_mode = RMSC_SHUT;
      endcase
      // config error beats every mode move decided above
      if (CONFIG_INVALID_I) next_mode = RMSC_ODIS;
      // shutdown is applied last so nothing can keep the device running
      if (!run) next_mode = RMSC_SHUT;
   end

   // mode register
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mode <= RMSC_SHUT;
      end else begin
         mode <= next_mode;
      end
   end

   // programmed flag: cleared by chip reset only, not by enable low
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         programmed <= 1'b0;
      end else if (!CHIP_RESET_LOW_I) begin
         programmed <= 1'b0;
      end else if (CONFIG_WRITE_I || TRAINING_DONE_I) begin
         programmed <= 1'b1;
      end
   end

   // config default strobe, held while chip reset is low
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         CONFIG_CLEAR_O <= 1'b1;
      end else begin
         CONFIG_CLEAR_O <= !CHIP_RESET_LOW_I;
      end
   end

   // mode output
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         MODE_O <= RMSC_SHUT;
      end else begin
         MODE_O <= next_mode;
      end
   end

   // presence to source follows presence so interrupt pulses pass straight through
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PRESENCE_TO_SOURCE_O <= 1'b0;
         CABLE_ADAPTER_TO_SOURCE_O <= 1'b0;
      end else begin
         PRESENCE_TO_SOURCE_O <= presence;
         CABLE_ADAPTER_TO_SOURCE_O <= presence && adapter;
      end
   end

   // lanes: on only in active with config programmed; tmds forces all four
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         LANE_EN_O <= `RMSC_NO_LANES;
      end else if (!CHIP_RESET_LOW_I || next_mode != RMSC_ACT || !programmed) begin
         LANE_EN_O <= `RMSC_NO_LANES;
      end else if (adapter) begin
         LANE_EN_O <= `RMSC_ALL_LANES;
      end else begin
         LANE_EN_O <= TRAINED_LANES_I;
      end
   end

   // training only in port mode; tmds holds swing defaults unless written
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         TRAINING_EN_O <= 1'b0;
         SWING_O <= `RMSC_SWING_DEF;
         EMPHASIS_O <= `RMSC_EMPH_DEF;
      end else begin
         TRAINING_EN_O <= run && presence && !adapter;
         if (!CHIP_RESET_LOW_I) begin
            SWING_O <= `RMSC_SWING_DEF;
            EMPHASIS_O <= `RMSC_EMPH_DEF;
         end else if (SWING_WRITE_I) begin
            SWING_O <= SWING_I;
            EMPHASIS_O <= EMPHASIS_I;
         end
      end
   end

   // sideband switch routing from the presence/adapter/setting table
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         SIDEBAND_O <= '0;
      end else if (!presence) begin
         SIDEBAND_O <= '0;
      end else if (!ALT_SIDEBAND_I) begin
         if (!adapter) SIDEBAND_O <= '{1'b1, 1'b1, 1'b0, 1'b1};
         else SIDEBAND_O <= '{1'b1, 1'b0, 1'b1, 1'b0};
      end else begin
         if (!adapter) SIDEBAND_O <= '{1'b0, 1'b1, 1'b0, 1'b1};
         else SIDEBAND_O <= '{1'b1, 1'b1, 1'b0, 1'b0};
      end
   end

   // ALT_JOIN_I reserved for the undocumented alternate sub-setting
   logic alt_join_unused;
   assign alt_join_unused = ALT_JOIN_I;

   shutdown_now_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      !run |=> MODE_O == RMSC_SHUT) else $error("not shut down after run low");
   wake_standby_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      mode == RMSC_SHUT && run && !CONFIG_INVALID_I |=> mode == RMSC_STBY) else $error("no standby");
   plug_active_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      mode == RMSC_STBY && run && presence && !CONFIG_INVALID_I |=> mode == RMSC_ACT) else $error("no active");
   unplug_timeout_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      run && !CONFIG_INVALID_I && unplugged && (mode == RMSC_ACT || mode == RMSC_D3) |=> mode == RMSC_STBY)
      else $error("no fall back on unplug");
   squelch_odis_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      CONFIG_INVALID_I && run |=> mode == RMSC_ODIS) else $error("invalid config not disabled");
   lanes_off_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      mode != RMSC_ACT |-> LANE_EN_O == `RMSC_NO_LANES) else $error("lanes on outside active");
   sideband_off_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      !presence |=> SIDEBAND_O == '0) else $error("sideband on without sink");
   irq_pass_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      1'b1 |=> PRESENCE_TO_SOURCE_O == $past(presence)) else $error("presence not passed");
   tmds_lanes_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      next_mode == RMSC_ACT && programmed && adapter && CHIP_RESET_LOW_I |=> LANE_EN_O == `RMSC_ALL_LANES)
      else $error("tmds lanes not all on");

   // building blocks for the mode-move checks below
   // a move is only owed while running, with valid config and a sink not yet timed out
   sequence settled_run;
      run && !CONFIG_INVALID_I && !unplugged;
   endsequence

   // power-down request from a port sink while active
   sequence d3_request;
      mode == RMSC_ACT && DEEP_POWER_DOWN_ENTRY_I && !adapter;
   endsequence

   // wake request while powered down: aux exit command or a tmds adapter
   sequence d3_wake;
      mode == RMSC_D3 && (DEEP_POWER_DOWN_EXIT_I || adapter);
   endsequence

   // stream lost while active, with no power-down request taking precedence
   sequence stream_lost;
      mode == RMSC_ACT && !STREAM_ACTIVE_I && !(DEEP_POWER_DOWN_ENTRY_I && !adapter);
   endsequence

   // stream back while squelched and the sink still present
   sequence stream_back;
      mode == RMSC_ODIS && presence && STREAM_ACTIVE_I;
   endsequence

   d3_entry_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      settled_run ##0 d3_request |=> mode == RMSC_D3) else $error("no deep power-down entry");
   d3_exit_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      settled_run ##0 d3_wake |=> mode == RMSC_ACT) else $error("no deep power-down exit");
   squelch_entry_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      settled_run ##0 stream_lost |=> mode == RMSC_ODIS) else $error("no squelch on lost stream");
   squelch_release_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      settled_run ##0 stream_back |=> mode == RMSC_ACT) else $error("no return on active stream");

   // port mode trains, tmds mode never does
   train_select_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      run && presence |=> TRAINING_EN_O == !$past(adapter)) else $error("training enable wrong for sink type");
   // adapter level reaches the source whenever a sink is present
   adapter_pass_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      presence |=> CABLE_ADAPTER_TO_SOURCE_O == $past(adapter)) else $error("adapter level not passed");
   // defaults held for every cycle the chip reset is low
   clear_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      !CHIP_RESET_LOW_I |=> CONFIG_CLEAR_O && !programmed) else $error("config not held at default");
endmodule

/* File: verilog/rmsc_params.svh */
/*
 constants of the re-driver mode and sideband controller: state codes, times, defaults.
 assumes inclusion by bare name from the package and the design file.
*/
`ifndef RMSC_PARAMS_SVH
`define RMSC_PARAMS_SVH
`define RMSC_CLK_MHZ 125
`define RMSC_IRQ_MIN_US 500
`define RMSC_IRQ_MAX_US 1000
`define RMSC_UNPLUG_US 2000
`define RMSC_ST_SHUT 3'h0
`define RMSC_ST_STBY 3'h1
`define RMSC_ST_ACT 3'h2
`define RMSC_ST_D3 3'h3
`define RMSC_ST_ODIS 3'h4
`define RMSC_LANES 4
`define RMSC_ALL_LANES 4'hf
`define RMSC_NO_LANES 4'h0
`define RMSC_SWING_DEF 2'h0
`define RMSC_EMPH_DEF 2'h0
`define RMSC_ZERO16 16'h0000
`define RMSC_ONE16 16'h0001
`endif

/* File: verilog/rmsc_pkg.sv */
/*
 types of the re-driver mode and sideband controller.
 assumes rmsc_params.svh on the include path.
*/
`include "rmsc_params.svh"
package rmsc_pkg;
   // operating modes
   typedef enum logic [2:0] {
      RMSC_SHUT = `RMSC_ST_SHUT,
      RMSC_STBY = `RMSC_ST_STBY,
      RMSC_ACT = `RMSC_ST_ACT,
      RMSC_D3 = `RMSC_ST_D3,
      RMSC_ODIS = `RMSC_ST_ODIS
   } rmsc_mode_t;
   // sideband switch states
   typedef struct packed {
      logic sink_aux_on;
      logic source_aux_on;
      logic ddc_on;
      logic aux_monitor_on;
   } rmsc_sideband_t;
   // local test overrides
   typedef struct packed {
      logic force_detect;
      logic presence_value;
      logic adapter_value;
   } rmsc_override_t;
endpackage

/* File: tb/rmsc_sink_model.sv */
/*
 sink-side model: presence and adapter detect, plus timed interrupt pulses.
 assumes a free-running clock; the pulse counter steps on the rising edge so it
 never races the bench's falling-edge stimulus.
*/
`timescale 1ns/1ps
module rmsc_sink_model #(
   parameter int IRQ_LOW = 75
) (
   input wire logic clk_i,
   input wire logic plug_i,
   input wire logic tmds_i,
   input wire logic irq_i,
   output logic presence_o,
   output logic adapter_o
);
   int low_cnt = 0; // interrupt low cycles left
   // a request pulls presence low for a fixed time inside the interrupt window
   always @(posedge clk_i) begin
      if (irq_i && low_cnt == 0) begin
         low_cnt <= IRQ_LOW;
      end else if (low_cnt > 0) begin
         low_cnt <= low_cnt - 1;
      end
   end
   // unplugged: the detect line falls to its pull-down level
   assign presence_o = plug_i && low_cnt == 0;
   assign adapter_o = plug_i ? tmds_i : 1'b0;
endmodule

/* File: tb/redriver_mode_sideband_ctrl_test.sv */
/*
 self-checking bench of the mode and sideband controller.
 assumes the sink model beside it; inputs change at the falling edge.
*/
`timescale 1ns/1ps
module redriver_mode_sideband_ctrl_test;
   import rmsc_pkg::*;
   logic clk = 0, rst = 1, en = 0, crl = 0, plug = 0, tmds = 0, irq = 0;
   logic d3_in = 0, d3_out = 0, stream = 1, inval = 0, cfg_wr = 0, alt = 0, swr = 0;
   logic [1:0] swing = 2'h0; // programmed swing
   logic [1:0] emph = 2'h0; // programmed emphasis
   logic trn_done = 0; // link training finished strobe
   rmsc_override_t ovr = '0; // local test override
   logic pres, adap, pres_src, adap_src, trn, clr;
   rmsc_mode_t mode;
   rmsc_sideband_t sb;
   logic [3:0] lanes;
   logic [1:0] swing_o, emph_o;
   int bad_count = 0, comparisons = 0;
   // 125 MHz clock
   always #4 clk = ~clk;
   rmsc_sink_model i_rmsc_sink_model (.clk_i(clk), .plug_i(plug), .tmds_i(tmds), .irq_i(irq),
      .presence_o(pres), .adapter_o(adap));
   // short counts keep the unplug wait small
   rmsc_ctrl #(.UNPLUG_CYCLES(200), .IRQ_MAX_CYCLES(100)) i_rmsc_ctrl (.CORE_CLK_I(clk), .RST_I(rst),
      .ENABLE_I(en), .CHIP_RESET_LOW_I(crl), .SINK_PRESENCE_IN_I(pres), .CABLE_ADAPTER_DETECT_IN_I(adap),
      .DEEP_POWER_DOWN_ENTRY_I(d3_in), .DEEP_POWER_DOWN_EXIT_I(d3_out), .STREAM_ACTIVE_I(stream),
      .CONFIG_INVALID_I(inval), .CONFIG_WRITE_I(cfg_wr), .TRAINING_DONE_I(trn_done), .TRAINED_LANES_I(4'h3),
      .ALT_SIDEBAND_I(alt), .ALT_JOIN_I(1'b0), .OVERRIDE_I(ovr), .SWING_WRITE_I(swr), .SWING_I(swing),
      .EMPHASIS_I(emph), .MODE_O(mode), .PRESENCE_TO_SOURCE_O(pres_src), .CABLE_ADAPTER_TO_SOURCE_O(adap_src),
      .SIDEBAND_O(sb), .LANE_EN_O(lanes), .TRAINING_EN_O(trn), .CONFIG_CLEAR_O(clr), .SWING_O(swing_o),
      .EMPHASIS_O(emph_o));
   // falling-edge pacing: outputs of the last rising edge are settled here
   task step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task check(input string what, input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task give_verdict;
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one-cycle strobe on a pulse input
   task automatic pulse(ref logic s);
      s = 1;
      step(1);
      s = 0;
   endtask
   // reset defaults, then leave shutdown with nothing plugged
   task t_start;
      step(2);
      check("mode", mode, RMSC_SHUT);
      check("clear", clr, 1'b1);
      check("lanes", lanes, 4'h0);
      rst = 0;
      step(1);
      en = 1;
      crl = 1;
      step(1);
      check("mode", mode, RMSC_STBY);
      check("sideband", sb, 4'h0);
   endtask
   // port sink: routing, lanes gated by programming, power-down, squelch, bad config
   task t_port;
      plug = 1;
      step(2);
      check("mode", mode, RMSC_ACT);
      check("presence", pres_src, 1'b1);
      check("sideband", sb, 4'hd);
      check("lanes", lanes, 4'h0);
      check("training", trn, 1'b1);
      check("adapter", adap_src, 1'b0);
      pulse(cfg_wr);
      step(1);
      check("lanes", lanes, 4'h3);
      alt = 1;
      step(2);
      check("sideband", sb, 4'h5);
      alt = 0;
      pulse(d3_in);
      check("mode", mode, RMSC_D3);
      pulse(d3_out);
      check("mode", mode, RMSC_ACT);
      pulse(d3_in);
      tmds = 1;
      step(1);
      check("mode", mode, RMSC_ACT);
      tmds = 0;
      stream = 0;
      step(1);
      check("mode", mode, RMSC_ODIS);
      stream = 1;
      step(1);
      check("mode", mode, RMSC_ACT);
      inval = 1;
      step(2);
      check("mode", mode, RMSC_ODIS);
      check("lanes", lanes, 4'h0);
      inval = 0;
      step(1);
      check("mode", mode, RMSC_ACT);
   endtask
   // sink interrupt pulse passes through without leaving active
   task t_irq;
      pulse(irq);
      step(40);
      check("presence", pres_src, 1'b0);
      check("mode", mode, RMSC_ACT);
      step(60);
      check("presence", pres_src, 1'b1);
   endtask
   // tmds sink: fixed defaults, all lanes, own routing, then overrides
   task t_tmds;
      tmds = 1;
      step(2);
      check("sideband", sb, 4'ha);
      check("adapter", adap_src, 1'b1);
      check("training", trn, 1'b0);
      check("swing", swing_o, 2'h0);
      check("emphasis", emph_o, 2'h0);
      check("lanes", lanes, 4'hf);
      alt = 1;
      step(2);
      check("sideband", sb, 4'hc);
      alt = 0;
      swing = 2'h2;
      emph = 2'h1;
      pulse(swr);
      step(1);
      check("swing", swing_o, 2'h2);
      check("emphasis", emph_o, 2'h1);
      ovr = '{1'b1, 1'b0, 1'b0};
      step(2);
      check("presence", pres_src, 1'b0);
      check("adapter", adap_src, 1'b0);
      ovr = '0;
   endtask
   // long unplug falls back to standby; then enable and chip reset drops
   task t_unplug;
      plug = 0;
      step(150);
      check("mode", mode, RMSC_ACT);
      step(60);
      check("mode", mode, RMSC_STBY);
      check("sideband", sb, 4'h0);
      en = 0;
      step(1);
      check("mode", mode, RMSC_SHUT);
      check("clear", clr, 1'b0);
      crl = 0;
      step(1);
      check("clear", clr, 1'b1);
      check("lanes", lanes, 4'h0);
   endtask
   // chip reset released again mid-run: config must be reprogrammed, here by training
   task t_restart;
      tmds = 0;
      plug = 1;
      en = 1;
      crl = 1;
      step(3);
      check("mode", mode, RMSC_ACT);
      check("lanes", lanes, 4'h0);
      pulse(trn_done);
      step(1);
      check("lanes", lanes, 4'h3);
   endtask
   // main sequence
   initial begin
      t_start;
      t_port;
      t_irq;
      t_tmds;
      t_unplug;
      t_restart;
      give_verdict;
   end
endmodule
